/* File: design/fsp_pkg.sv */
// Constants, field positions and enumerations for the flash status and protection block.
package fsp_pkg;

    // ==========================================================
    // Array geometry
    localparam int ADDR_W = 24;
    localparam int SW_W = 16;
    localparam int SECTOR_LOG = 12;
    localparam int BLK32_LOG = 15;
    localparam int BLK64_LOG = 16;
    localparam int FRACT_BASE_LOG = 17;
    localparam int SMALL_BASE_LOG = 11;
    localparam int SMALL_MAX_LOG = 15;
    localparam logic [2:0] SMALL_MAX_CODE = 3'h4;
    localparam logic [2:0] BP_CODE_NONE = 3'h0;
    localparam logic [2:0] BP_CODE_ALL = 3'h7;
    localparam int SEC_IDX_LO = 12;

    // ==========================================================
    // Status word layout
    localparam int BIT_BUSY = 0;
    localparam int BIT_WEL = 1;
    localparam int BP_LO = 2;
    localparam int BP_HI = 6;
    localparam int BIT_STATUS_LOCK_LO = 7;
    localparam int BIT_STATUS_LOCK_HI = 8;
    localparam int BIT_QE = 9;
    localparam int BIT_PSUS = 10;
    localparam int LB_LO = 11;
    localparam int LB_HI = 13;
    localparam int BIT_CMP = 14;
    localparam int BIT_ESUS = 15;
    localparam logic [SW_W-1:0] NV_MASK = 16'h7BFC;
    localparam logic [SW_W-1:0] STATUS_RESET = 16'h0000;

    // ==========================================================
    // Status-protect modes
    localparam logic [1:0] SRP_SOFT = 2'h0;
    localparam logic [1:0] SRP_HW = 2'h1;
    localparam logic [1:0] SRP_LOCKDOWN = 2'h2;
    localparam logic [1:0] SRP_OTP = 2'h3;

    // ==========================================================
    // Operations delivered by the command decoder
    typedef enum logic [3:0] {
        OP_WRITE_ENABLE_CMD = 4'h0,
        OP_WRDI = 4'h1,
        OP_STATUS_WRITE_CMD = 4'h2,
        OP_PP = 4'h3,
        OP_SE = 4'h4,
        OP_BE32 = 4'h5,
        OP_BE64 = 4'h6,
        OP_CE = 4'h7,
        OP_SUSPEND = 4'h8,
        OP_RESUME = 4'h9,
        OP_RST_EN = 4'hA,
        OP_RST = 4'hB,
        OP_SEC_ERASE = 4'hC,
        OP_SEC_PROG = 4'hD
    } fsp_op_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_BUSY = 2'h1,
        ST_SUSP = 2'h2
    } fsp_state_type;

endpackage : fsp_pkg

/* File: design/fsp_status_protect.sv */
// Status word, write latch and array protection of a serial flash, with link-clock crossing.
// What this block does
// R1: Busy flag is 1 while program, erase or status write runs, else 0.
// R2: Write latch shows in the status word; when 0, writes, programs, erases refused.
// R3: Status word bit layout from busy at bit 0 to erase-suspend at 15.
// R4: Protect bits change only by status write, never in hardware protected mode.
// R5: Program, sector and block erase refused inside the protected range.
// R6: Chip erase only with low protect bits 000 and complement 0, or 111 and 1.
// R7: Complement 1 inverts the protected range decode.
// R8: Complement bit at 14 is non-volatile, default 0, joins the range decode.
// R9: Status-protect 00: status write allowed when idle with the write latch set.
// R10: Status-protect 01: low protect pin locks status; high allows with latch.
// R11: Status-protect 10 refuses status writes until power cycle, which restores 00.
// R12: Status-protect 11 refuses every status write permanently.
// R13: Quad enable is non-volatile, default 0, output as quad_enable; the protect pin still gates status-protect 01.
// R14: Security lock bits default 0, set once, then security registers read-only.
// R15: Suspend sets erase or program suspend flag by the suspended operation.
// R16: Resume, software reset pair or power cycle clear both suspend flags.
// R17: Status-protect bits are non-volatile and select the status protection mode.
// R18: Protect code 11100 with complement 0 protects the bottom 32KB.
// R19: Complement 0 decode: fractions of the array or 4KB to 32KB, top or bottom.
// R20: Write latch clears at power-up, write-disable and on completion of writes.
// R21: Status write keeps busy, latch and suspend flags, cannot clear lock bits.
module fsp_status_protect #(
    parameter int ADDR_BITS = fsp_pkg::ADDR_W
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic link_reset,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire fsp_pkg::fsp_op_type cmd_op,
    input wire logic [fsp_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [fsp_pkg::SW_W-1:0] cmd_data,
    output logic [fsp_pkg::SW_W-1:0] status_rd,
    input wire logic write_protect_n,
    input wire logic [fsp_pkg::SW_W-1:0] nv_image,
    input wire logic op_done,
    output logic array_start,
    output fsp_pkg::fsp_op_type array_op,
    output logic [fsp_pkg::ADDR_W-1:0] array_addr,
    output logic array_suspend,
    output logic array_resume,
    output logic array_abort,
    output logic [fsp_pkg::SW_W-1:0] nv_status,
    output logic [fsp_pkg::SW_W-1:0] status_word,
    output logic quad_enable,
    output logic [2:0] security_locked
);
    import fsp_pkg::*;

    if (ADDR_BITS != ADDR_W) begin : g_bad_addr
        $error("fsp_status_protect supports only the package address width");
    end

    // ==========================================================
    // Protection decode
    function automatic logic prot_hit(input logic [4:0] bp, input logic cmp,
                                      input logic [ADDR_W-1:0] addr);
        logic [2:0] code;
        logic hit;
        int unsigned sz_log;
        logic [ADDR_W:0] size;
        logic [ADDR_W:0] top;
        code = bp[2:0];
        top = (ADDR_W+1)'(1) << ADDR_W;
        if (bp[4]) begin
            sz_log = (code >= SMALL_MAX_CODE) ? SMALL_MAX_LOG : SMALL_BASE_LOG + code;
        end else begin
            sz_log = FRACT_BASE_LOG + code;
        end
        size = (ADDR_W+1)'(1) << sz_log;
        if (code == BP_CODE_NONE) begin
            hit = 1'b0;
        end else if (code == BP_CODE_ALL) begin
            hit = 1'b1;
        end else if (bp[3]) begin
            hit = {1'b0, addr} < size; // [R18] [R19]
        end else begin
            hit = {1'b0, addr} >= (top - size); // [R19]
        end
        return cmp ? ~hit : hit; // [R7] [R8]
    endfunction : prot_hit

    function automatic logic span_hit(input logic [4:0] bp, input logic cmp,
                                      input logic [ADDR_W-1:0] addr, input int unsigned lg);
        logic [ADDR_W-1:0] mask;
        mask = ADDR_W'((ADDR_W+1)'(1) << lg) - ADDR_W'(1);
        return prot_hit(bp, cmp, addr & ~mask) | prot_hit(bp, cmp, addr | mask);
    endfunction : span_hit

    // ==========================================================
    // Link domain: command capture and status view
    fsp_op_type op_l_q;
    logic [ADDR_W-1:0] addr_l_q;
    logic [SW_W-1:0] data_l_q;
    logic req_tog_l_q, ack_l_s1_q, ack_l_s2_q;
    logic snap_l_s1_q, snap_l_s2_q, snap_l_s3_q;
    logic [SW_W-1:0] status_rd_q;
    logic ack_tog_q, snap_tog_q;
    logic [SW_W-1:0] snap_q;

    assign cmd_ready = (req_tog_l_q == ack_l_s2_q);
    assign status_rd = status_rd_q;

    always_ff @(posedge sclk) begin
        if (link_reset) begin
            op_l_q <= OP_WRDI;
            addr_l_q <= '0;
            data_l_q <= '0;
            req_tog_l_q <= 1'b0;
        end else if (cmd_valid && cmd_ready) begin
            op_l_q <= cmd_op;
            addr_l_q <= cmd_addr;
            data_l_q <= cmd_data;
            req_tog_l_q <= ~req_tog_l_q;
        end
    end

    always_ff @(posedge sclk) begin
        if (link_reset) begin
            ack_l_s1_q <= 1'b0;
            ack_l_s2_q <= 1'b0;
            snap_l_s1_q <= 1'b0;
            snap_l_s2_q <= 1'b0;
            snap_l_s3_q <= 1'b0;
            status_rd_q <= STATUS_RESET;
        end else begin
            ack_l_s1_q <= ack_tog_q;
            ack_l_s2_q <= ack_l_s1_q;
            snap_l_s1_q <= snap_tog_q;
            snap_l_s2_q <= snap_l_s1_q;
            snap_l_s3_q <= snap_l_s2_q;
            if (snap_l_s2_q != snap_l_s3_q) begin
                status_rd_q <= snap_q;
            end
        end
    end

    // ==========================================================
    // Core domain synchronisers
    logic req_s1_q, req_s2_q, req_s3_q, wp_s1_q, wp_s2_q, sack_s1_q, sack_s2_q;
    logic req_new;

    always_ff @(posedge clk) begin
        if (reset) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
            wp_s1_q <= 1'b1;
            wp_s2_q <= 1'b1;
            sack_s1_q <= 1'b0;
            sack_s2_q <= 1'b0;
            ack_tog_q <= 1'b0;
        end else begin
            req_s1_q <= req_tog_l_q;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
            wp_s1_q <= write_protect_n;
            wp_s2_q <= wp_s1_q;
            sack_s1_q <= snap_l_s3_q;
            sack_s2_q <= sack_s1_q;
            ack_tog_q <= req_s3_q;
        end
    end
    assign req_new = req_s2_q != req_s3_q;

    // ==========================================================
    // Status state and decisions
    fsp_state_type state_q;
    fsp_op_type run_op_q;
    logic write_latch_q, erase_suspended_flag_q, program_suspended_flag_q, rst_arm_q;
    logic [SW_W-1:0] nv_q;
    logic [4:0] bp;
    logic [1:0] srp;
    logic cmp, sr_ok, go, wel_set, wel_clr, sus_ok, res_ok, rst_go, erase_run, wr_done;
    logic [1:0] sec_idx;

    assign bp = nv_q[BP_HI:BP_LO];
    assign srp = {nv_q[BIT_STATUS_LOCK_HI], nv_q[BIT_STATUS_LOCK_LO]};
    assign cmp = nv_q[BIT_CMP];
    assign sec_idx = addr_l_q[SEC_IDX_LO+1:SEC_IDX_LO];
    assign erase_run = run_op_q inside {OP_SE, OP_BE32, OP_BE64, OP_CE, OP_SEC_ERASE};
    assign wr_done = op_done && state_q == ST_BUSY;

    always_comb begin
        sr_ok = write_latch_q && (srp == SRP_SOFT || (srp == SRP_HW && wp_s2_q)); // [R9] [R10] [R11] [R12] [R17]
        go = 1'b0;
        wel_set = 1'b0;
        wel_clr = 1'b0;
        sus_ok = 1'b0;
        res_ok = 1'b0;
        rst_go = 1'b0;
        if (req_new) begin
            case (op_l_q)
                OP_WRITE_ENABLE_CMD: wel_set = state_q != ST_BUSY;
                OP_WRDI: wel_clr = state_q != ST_BUSY; // [R20]
                OP_STATUS_WRITE_CMD: go = sr_ok;
                OP_PP: go = write_latch_q && !prot_hit(bp, cmp, addr_l_q); // [R2] [R5]
                OP_SE: go = write_latch_q && !span_hit(bp, cmp, addr_l_q, SECTOR_LOG); // [R5]
                OP_BE32: go = write_latch_q && !span_hit(bp, cmp, addr_l_q, BLK32_LOG);
                OP_BE64: go = write_latch_q && !span_hit(bp, cmp, addr_l_q, BLK64_LOG);
                OP_CE: go = write_latch_q && ((bp[2:0] == BP_CODE_NONE && !cmp) ||
                                              (bp[2:0] == BP_CODE_ALL && cmp)); // [R6]
                OP_SEC_ERASE, OP_SEC_PROG: go = write_latch_q && sec_idx != 2'h0 &&
                                                 !nv_q[LB_LO + int'(sec_idx) - 1]; // [R14]
                OP_SUSPEND: sus_ok = state_q == ST_BUSY && run_op_q != OP_STATUS_WRITE_CMD;
                OP_RESUME: res_ok = state_q == ST_SUSP;
                OP_RST: rst_go = rst_arm_q;
                default: go = 1'b0;
            endcase
            if (state_q != ST_IDLE) begin
                go = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            run_op_q <= OP_WRDI;
        end else begin
            case (state_q)
                ST_IDLE: if (go) begin
                    state_q <= ST_BUSY; // [R1]
                    run_op_q <= op_l_q;
                end
                ST_BUSY: if (op_done) begin
                    state_q <= ST_IDLE; // [R1]
                end else if (sus_ok) begin
                    state_q <= ST_SUSP;
                end
                ST_SUSP: if (res_ok) begin
                    state_q <= ST_BUSY;
                end else if (rst_go) begin
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            write_latch_q <= 1'b0; // [R20]
        end else if (wel_set) begin
            write_latch_q <= 1'b1;
        end else if (wel_clr || rst_go || (wr_done && run_op_q != OP_WRITE_ENABLE_CMD)) begin
            write_latch_q <= 1'b0; // [R20]
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            nv_q <= nv_image & NV_MASK;
            if ({nv_image[BIT_STATUS_LOCK_HI], nv_image[BIT_STATUS_LOCK_LO]} == SRP_LOCKDOWN) begin
                nv_q[BIT_STATUS_LOCK_HI] <= 1'b0; // [R11]
            end
        end else if (go && op_l_q == OP_STATUS_WRITE_CMD) begin
            nv_q <= (data_l_q & NV_MASK) | (nv_q & (SW_W'(7) << LB_LO)); // [R4] [R13] [R21]
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            erase_suspended_flag_q <= 1'b0;
            program_suspended_flag_q <= 1'b0;
        end else if (res_ok || rst_go) begin
            erase_suspended_flag_q <= 1'b0; // [R16]
            program_suspended_flag_q <= 1'b0;
        end else if (sus_ok && !op_done) begin
            erase_suspended_flag_q <= erase_run; // [R15]
            program_suspended_flag_q <= !erase_run;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rst_arm_q <= 1'b0;
        end else if (req_new) begin
            rst_arm_q <= op_l_q == OP_RST_EN;
        end
    end

    // ==========================================================
    // Array engine controls
    logic array_start_q, array_suspend_q, array_resume_q, array_abort_q;
    fsp_op_type array_op_q;
    logic [ADDR_W-1:0] array_addr_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            array_start_q <= 1'b0;
            array_suspend_q <= 1'b0;
            array_resume_q <= 1'b0;
            array_abort_q <= 1'b0;
            array_op_q <= OP_WRDI;
            array_addr_q <= '0;
        end else begin
            array_start_q <= go;
            array_suspend_q <= sus_ok && !op_done;
            array_resume_q <= res_ok;
            array_abort_q <= rst_go && state_q == ST_SUSP;
            if (go) begin
                array_op_q <= op_l_q;
                array_addr_q <= addr_l_q;
            end
        end
    end

    assign array_start = array_start_q;
    assign array_op = array_op_q;
    assign array_addr = array_addr_q;
    assign array_suspend = array_suspend_q;
    assign array_resume = array_resume_q;
    assign array_abort = array_abort_q;
    assign nv_status = nv_q;
    assign quad_enable = nv_q[BIT_QE];
    assign security_locked = nv_q[LB_HI:LB_LO];

    // ==========================================================
    // Status word and its copy toward the link
    always_comb begin
        status_word = nv_q; // [R3]
        status_word[BIT_BUSY] = state_q == ST_BUSY; // [R1]
        status_word[BIT_WEL] = write_latch_q; // [R2]
        status_word[BIT_PSUS] = program_suspended_flag_q;
        status_word[BIT_ESUS] = erase_suspended_flag_q;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            snap_q <= STATUS_RESET;
            snap_tog_q <= 1'b0;
        end else if (snap_tog_q == sack_s2_q && snap_q != status_word) begin
            snap_q <= status_word;
            snap_tog_q <= ~snap_tog_q;
        end
    end

    // ==========================================================
    // Checks
    a_busy_start: assert property (@(posedge clk) disable iff (reset)
        go |=> status_word[BIT_BUSY]) else $error("busy flag not raised on start"); // [R1]
    a_busy_done: assert property (@(posedge clk) disable iff (reset)
        wr_done |=> !status_word[BIT_BUSY]) else $error("busy flag stuck after done"); // [R1]
    a_latch_refuse: assert property (@(posedge clk) disable iff (reset)
        array_start |-> $past(write_latch_q)) else $error("start without write latch"); // [R2]
    a_hw_bp_lock: assert property (@(posedge clk) disable iff (reset)
        (srp == SRP_HW && !wp_s2_q) |=> $stable(bp)) else $error("protect bits moved"); // [R4]
    a_pp_protect: assert property (@(posedge clk) disable iff (reset)
        (array_start && array_op == OP_PP) |-> !$past(prot_hit(bp, cmp, addr_l_q)))
        else $error("program into protected range"); // [R5]
    a_ce_gate: assert property (@(posedge clk) disable iff (reset)
        (go && op_l_q == OP_CE) |-> (bp[2:0] == {3{cmp}}))
        else $error("chip erase under protection"); // [R6]
    a_srp_locked: assert property (@(posedge clk) disable iff (reset)
        srp[1] |=> $stable(nv_q)) else $error("status changed while locked"); // [R11] [R12]
    a_lock_sticky: assert property (@(posedge clk) disable iff (reset)
        ##1 ((security_locked & $past(security_locked)) == $past(security_locked)))
        else $error("lock bit cleared"); // [R14]
    a_sus_clear: assert property (@(posedge clk) disable iff (reset)
        res_ok |=> !erase_suspended_flag_q && !program_suspended_flag_q ##1 array_resume == 1'b0)
        else $error("suspend flags not cleared"); // [R16]
    a_latch_clear: assert property (@(posedge clk) disable iff (reset)
        (wr_done && !wel_set) |=> !write_latch_q) else $error("latch kept after write"); // [R20]

endmodule : fsp_status_protect

/* File: tb/fsp_engine_model.sv */
// Behavioural array engine that completes each started operation after a set delay unless array_abort ends it first.
module fsp_engine_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic array_start,
    input wire logic array_suspend,
    input wire logic array_resume,
    input wire logic array_abort,
    input wire logic [15:0] delay,
    output logic op_done
);
    timeunit 1ns;
    timeprecision 1ps;

    logic running_q;
    logic held_q;
    logic [15:0] cnt_q;

    // ==========================================================
    // Operation timer
    // The timer freezes while suspended, but a completion that falls due before the
    // registered array_suspend reaches it still fires.
    always_ff @(posedge clk) begin
        op_done <= 1'h0;
        if (reset) begin
            running_q <= 1'h0;
            held_q <= 1'h0;
            cnt_q <= 16'h0;
        end else if (array_start) begin
            running_q <= 1'h1;
            held_q <= 1'h0;
            cnt_q <= delay;
        end else if (array_abort) begin
            running_q <= 1'h0;
        end else if (array_suspend) begin
            held_q <= 1'h1;
        end else if (array_resume) begin
            held_q <= 1'h0;
        end else if (running_q && !held_q) begin
            if (cnt_q == 16'h0) begin
                op_done <= 1'h1;
                running_q <= 1'h0;
            end else begin
                cnt_q <= cnt_q - 16'h1;
            end
        end
    end
endmodule : fsp_engine_model

/* File: tb/fsp_status_protect_tb.sv */
// Self-checking bench for the flash status word and array protection block.
module fsp_status_protect_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fsp_pkg::*;

    logic clk = 1'h0, sclk = 1'h0, reset = 1'h1, link_reset = 1'h1, cmd_valid = 1'h0;
    logic write_protect_n = 1'h1;
    fsp_op_type cmd_op = OP_WRITE_ENABLE_CMD;
    fsp_op_type array_op;
    logic [23:0] cmd_addr = 24'h0;
    logic [23:0] array_addr;
    logic [15:0] cmd_data = 16'h0, nv_image = 16'h0, exp_st = 16'h0, eng_delay = 16'h2;
    logic [15:0] status_rd, nv_status, status_word;
    logic cmd_ready, op_done, array_start, array_suspend, array_resume, array_abort;
    logic quad_enable;
    logic [2:0] security_locked;
    logic [31:0] seed = 32'h2D99;
    int error_cnt = 0, samples_checked = 0, starts = 0, aborts = 0;
    fsp_op_type ops [4] = '{OP_PP, OP_SE, OP_BE32, OP_BE64};
    logic [23:0] spans [4] = '{24'h0, 24'hFFF, 24'h7FFF, 24'hFFFF};

    always #2 clk = ~clk;
    always #62.5 sclk = ~sclk;

    fsp_status_protect #(.ADDR_BITS(24)) dut_u (.clk(clk), .reset(reset), .sclk(sclk),
        .link_reset(link_reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .status_rd(status_rd),
        .write_protect_n(write_protect_n), .nv_image(nv_image), .op_done(op_done),
        .array_start(array_start), .array_op(array_op), .array_addr(array_addr),
        .array_suspend(array_suspend), .array_resume(array_resume),
        .array_abort(array_abort), .nv_status(nv_status), .status_word(status_word),
        .quad_enable(quad_enable), .security_locked(security_locked));

    fsp_engine_model eng_u (.clk(clk), .reset(reset), .array_start(array_start),
        .array_suspend(array_suspend), .array_resume(array_resume),
        .array_abort(array_abort), .delay(eng_delay), .op_done(op_done));

    always @(posedge clk) begin
        if (array_start === 1'h1) starts <= starts + 1;
        if (array_abort === 1'h1) aborts <= aborts + 1;
    end

    // ==========================================================
    // Helpers
    function logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : next_rand

    // Protected-range decode worked out independently of the design.
    function automatic logic prot(input logic [4:0] bp, input logic cmp, input logic [23:0] a);
        logic p;
        int lg;
        lg = bp[4] ? 11 + ((bp[2:0] > 3'h4) ? 4 : int'(bp[2:0])) : 17 + int'(bp[2:0]);
        if (bp[2:0] == 3'h0) p = 1'h0;
        else if (bp[2:0] == 3'h7) p = 1'h1;
        else if (bp[3]) p = int'(a) < (1 << lg);
        else p = int'(a) >= (1 << 24) - (1 << lg);
        return p ^ cmp;
    endfunction : prot

    task report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    task check(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task timed_out();
        error_cnt++;
        report_and_stop();
    endtask : timed_out

    task send(input fsp_op_type op, input logic [23:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(negedge sclk);
        while (cmd_ready !== 1'h1 && n < 64) begin
            @(negedge sclk);
            n++;
        end
        if (n >= 64) timed_out();
        cmd_valid = 1'h1;
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        @(posedge sclk);
        @(negedge sclk);
        cmd_valid = 1'h0;
    endtask : send

    task wait_done(input logic need_idle);
        int n;
        n = 0;
        @(negedge sclk);
        while (!(cmd_ready === 1'h1 && (!need_idle || status_word[0] === 1'h0)) && n < 4000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 4000) timed_out();
        repeat (12) @(negedge clk);
    endtask : wait_done

    task do_reset(input logic [15:0] nv);
        @(negedge clk);
        reset = 1'h1;
        link_reset = 1'h1;
        nv_image = nv;
        repeat (2) @(posedge sclk);
        @(negedge clk);
        reset = 1'h0;
        @(negedge sclk);
        link_reset = 1'h0;
        repeat (8) @(negedge clk);
        exp_st = nv & 16'h7BFC;
        if (exp_st[8:7] == 2'h2) exp_st[8] = 1'h0;
        check(24'(status_word), 24'(exp_st));
        check(24'({quad_enable, security_locked}), 24'({exp_st[9], exp_st[13:11]}));
    endtask : do_reset

    task status_write_cmd(input logic [15:0] d, input logic ok);
        send(OP_WRITE_ENABLE_CMD, 24'h0, 16'h0);
        wait_done(1'h1);
        send(OP_STATUS_WRITE_CMD, 24'h0, d);
        wait_done(1'h1);
        if (ok) exp_st = (d & 16'h7BFC) | (exp_st & 16'h3800);
        check(24'(status_word), 24'(ok ? exp_st : exp_st | 16'h0002));
        if (!ok) begin
            send(OP_WRDI, 24'h0, 16'h0);
            wait_done(1'h1);
            check(24'(status_word), 24'(exp_st));
        end
        repeat (6) @(negedge sclk);
        check(24'(status_rd), 24'(exp_st));
        check(24'(nv_status), 24'(exp_st));
    endtask : status_write_cmd

    task try_op(input fsp_op_type op, input logic [23:0] a, input logic go);
        int s;
        send(OP_WRITE_ENABLE_CMD, 24'h0, 16'h0);
        wait_done(1'h1);
        s = starts;
        send(op, a, 16'h0);
        wait_done(1'h1);
        check(24'(starts - s), 24'(go));
        if (go) begin
            check(array_addr, a);
            check(24'(array_op), 24'(op));
            check(24'(status_word[1:0]), 24'h0);
        end
    endtask : try_op

    // ==========================================================
    // Main sequence
    initial begin
        int i, j;
        logic [4:0] bp;
        logic cmp;
        logic [23:0] a;
        logic [31:0] r;
        r = next_rand();
        do_reset({r[15:9], 2'h2, r[6:0]});
        do_reset(16'h0000);
        @(negedge clk);
        write_protect_n = 1'h0;
        status_write_cmd(16'h0004, 1'h1);
        status_write_cmd(16'h0080, 1'h1);
        status_write_cmd(16'h0088, 1'h0);
        @(negedge clk);
        write_protect_n = 1'h1;
        status_write_cmd(16'h0088, 1'h1);
        status_write_cmd(16'h8603, 1'h1);
        check(24'(quad_enable), 24'h1);
        status_write_cmd(16'h2800, 1'h1);
        status_write_cmd(16'h0000, 1'h1);
        check(24'(security_locked), 24'h5);
        try_op(OP_SEC_PROG, 24'h001000, 1'h0);
        try_op(OP_SEC_ERASE, 24'h003000, 1'h0);
        try_op(OP_SEC_PROG, 24'h002000, 1'h1);
        try_op(OP_SEC_ERASE, 24'h000000, 1'h0);
        send(OP_WRDI, 24'h0, 16'h0);
        wait_done(1'h1);
        i = starts;
        send(OP_PP, 24'h0, 16'h0);
        wait_done(1'h1);
        send(OP_STATUS_WRITE_CMD, 24'h0, 16'h0200);
        wait_done(1'h1);
        check(24'(starts - i), 24'h0);
        check(24'(status_word), 24'(exp_st));
        status_write_cmd(16'h0070, 1'h1);
        try_op(OP_PP, 24'h007FFF, 1'h0);
        try_op(OP_PP, 24'h008000, 1'h1);
        for (i = 0; i < 20; i++) begin
            r = next_rand();
            bp = r[4:0];
            cmp = r[5];
            status_write_cmd({1'h0, cmp, 7'h00, bp, 2'h0}, 1'h1);
            for (j = 0; j < 4; j++) begin
                r = next_rand();
                a = (j == 0) ? 24'h0 : (j == 1) ? 24'hFFFFFF : r[23:0];
                a = a & ~spans[j];
                try_op(ops[j], a, !(prot(bp, cmp, a) || prot(bp, cmp, a | spans[j])));
            end
        end
        for (i = 0; i < 8; i++) begin
            r = next_rand();
            bp = {r[1:0], (i < 2) ? 3'h0 : (i < 4) ? 3'h7 : 3'(1 + r[7:4] % 6)};
            cmp = i[0];
            status_write_cmd({1'h0, cmp, 7'h00, bp, 2'h0}, 1'h1);
            try_op(OP_CE, 24'h0, (bp[2:0] == 3'h0 && !cmp) || (bp[2:0] == 3'h7 && cmp));
        end
        status_write_cmd(16'h0000, 1'h1);
        eng_delay = 16'h190;
        send(OP_WRITE_ENABLE_CMD, 24'h0, 16'h0);
        wait_done(1'h1);
        send(OP_SE, 24'h001000, 16'h0);
        wait_done(1'h0);
        send(OP_SUSPEND, 24'h0, 16'h0);
        wait_done(1'h0);
        check(24'(status_word & 16'hFFFD), 24'(exp_st | 16'h8000));
        send(OP_RESUME, 24'h0, 16'h0);
        wait_done(1'h0);
        check(24'(status_word & 16'hFFFD), 24'(exp_st | 16'h0001));
        wait_done(1'h1);
        check(24'(status_word), 24'(exp_st));
        send(OP_WRITE_ENABLE_CMD, 24'h0, 16'h0);
        wait_done(1'h1);
        send(OP_PP, 24'h002000, 16'h0);
        wait_done(1'h0);
        send(OP_SUSPEND, 24'h0, 16'h0);
        wait_done(1'h0);
        check(24'(status_word & 16'hFFFD), 24'(exp_st | 16'h0400));
        i = aborts;
        send(OP_RST_EN, 24'h0, 16'h0);
        wait_done(1'h0);
        send(OP_RST, 24'h0, 16'h0);
        wait_done(1'h0);
        check(24'(status_word), 24'(exp_st));
        check(24'(aborts - i), 24'h1);
        eng_delay = 16'h2;
        status_write_cmd(16'h0100, 1'h1);
        status_write_cmd(16'h0004, 1'h0);
        do_reset(exp_st);
        status_write_cmd(16'h0180, 1'h1);
        status_write_cmd(16'h0004, 1'h0);
        report_and_stop();
    end
endmodule : fsp_status_protect_tb
